// ---- bench/tb_wakeup_frame_filter.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_wakeup_frame_filter;
    localparam logic [47:0] STATION = 48'h665544332210;
    localparam logic [47:0] PEER = 48'hccbbaa998870;
    typedef struct {
        logic [11:0] a;
        logic [31:0] d;
        logic [31:0] e;
    } wff_row_t;
    wff_row_t rows [6] = '{'{12'h16c, 32'hfc000000, 32'h80000000},
        '{12'h27c, 32'ha5a5a5a5, 32'ha5a5a5a5},
        '{12'h420, 32'hffffffff, 32'hc000ffff},
        '{12'h424, 32'h12345678, 32'h12345678},
        '{12'h508, 32'hffffffff, 32'h0}, '{12'h1d0, 32'hffffffff, 32'h0}};
    logic         clock = 1'b0;
    logic         nrst = 1'b0;
    logic         usb_reset = 1'b0;
    logic         lite_reset = 1'b0;
    logic         image_load = 1'b0;
    logic [31:0]  image_cfg = 32'h0;
    logic [127:0] image_mask = 128'h0;
    logic [11:0]  bus_addr = 12'h0;
    logic [31:0]  bus_wdata = 32'h0;
    logic         bus_wr = 1'b0;
    logic         bus_rd = 1'b0;
    logic [4:0]   wake_en = 5'h1f;
    logic         entering_suspend = 1'b0;
    logic         waking_up = 1'b0;
    logic [31:0]  bus_rdata;
    logic [7:0]   rx_data;
    logic         rx_sof, rx_valid, rx_eof, rx_frame_ok;
    logic         rx_filter_pass, rx_magic_packet;
    logic         wake_signal, perfect_da_hit, perfect_sa_hit;
    int           n_mismatch = 0;
    int           checks_done = 0;
    wff_wake_filter dut (.clock, .nrst, .usb_reset, .lite_reset, .image_load,
        .image_cfg, .image_mask, .bus_addr, .bus_wdata, .bus_wr, .bus_rd,
        .bus_rdata, .rx_sof, .rx_valid, .rx_data, .rx_eof, .rx_frame_ok,
        .rx_filter_pass, .rx_magic_packet, .station_address(STATION),
        .filter_engine_wake_en(wake_en[4]), .own_address_wake_en(wake_en[3]),
        .magic_packet_wake_en(wake_en[2]), .broadcast_wake_en(wake_en[1]),
        .pattern_frame_wake_en(wake_en[0]), .entering_suspend, .waking_up,
        .wake_signal, .perfect_da_hit, .perfect_sa_hit);
    wff_rx_source rx (.clock, .rx_sof, .rx_valid, .rx_data, .rx_eof,
        .rx_frame_ok, .rx_filter_pass, .rx_magic_packet);
    always #25 clock = ~clock;
    task automatic chk(input string name, input logic [31:0] exp, got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        {bus_addr, bus_wdata, bus_wr} <= {a, d, 1'b1};
        @(posedge clock);
        bus_wr <= 1'b0;
    endtask
    task automatic rdchk(input string name, input logic [11:0] a,
                         input logic [31:0] exp);
        @(posedge clock);
        {bus_addr, bus_rd} <= {a, 1'b1};
        @(posedge clock);
        bus_rd <= 1'b0;
        @(negedge clock);
        chk(name, exp, bus_rdata);
    endtask
    task automatic fill(input logic [47:0] da);
        for (int i = 0; i < 64; i++)
            rx.frame_bytes[i] = i < 6 ? da[8*i +: 8] : i < 12 ?
                PEER[8*(i-6) +: 8] : 8'(i * 37);
    endtask
    // Pattern offset is fixed at 2 here, so only bytes 2..63 are eligible.
    function automatic logic [15:0] crc_of(input logic [127:0] m);
        logic [15:0] c;
        logic [7:0]  d;
        c = 16'hffff;
        for (int j = 0; j < 62; j++) begin
            d = rx.frame_bytes[j+2];
            for (int b = 0; b < 8; b++)
                if (m[j])
                    c = {c[14:0], 1'b0} ^ ((c[15] ^ d[b]) ? 16'h8005 : 16'h0);
        end
        return c;
    endfunction
    task automatic frame(input logic ok, pass, magic, input int gap,
                         input logic wk, input logic [31:0] src);
        rx.send(64, ok, pass, magic, gap);
        @(negedge clock);
        chk("wake_signal", {31'h0, wk}, {31'h0, wake_signal});
        rdchk("wake_source_status", 12'h144, src);
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        n_mismatch++;
        print_verdict();
    end
    initial begin
        logic [127:0] m;
        logic [1:0]   t;
        logic [4:0]   idx;
        logic         hit;
        m = 128'h100_0000_0005;
        idx = 5'h0;
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        rdchk("wake_source_status", 12'h144, 32'h0);
        rdchk("wake_filter_config", 12'h150, 32'h0);
        foreach (rows[k]) begin
            wr(rows[k].a, rows[k].d);
            rdchk("register row", rows[k].a, rows[k].e);
        end
        for (int f = 1; f < 4; f += 2) begin
            wr(12'h200 + 12'(16 * f), m[31:0]);
            wr(12'h204 + 12'(16 * f), m[63:32]);
        end
        // Filter 1 carries the same pattern but stays disabled.
        for (int k = 0; k < 8; k++) begin
            t = 2'(k >> 1);
            hit = t[0] | (t[1] == k[0]);
            fill(48'h0a0908070604 | 48'(k & 1));
            wr(12'h15c, {6'h20, t, 8'h02, crc_of(m)});
            wr(12'h154, {6'h00, t, 8'h02, crc_of(m)});
            if (hit)
                idx = 5'h3;
            frame(1'b1, 1'b0, 1'b0, k % 3, hit,
                  {23'h0, hit, 3'h0, idx});
            wr(12'h144, 32'h1f00);
        end
        wr(12'h15c, 32'h0);
        fill(48'hffffffffffff);
        frame(1'b1, 1'b1, 1'b1, 0, 1'b1, 32'h1603);
        frame(1'b0, 1'b1, 1'b1, 1, 1'b0, 32'h1603);
        wr(12'h144, 32'h1f00);
        wr(12'h400, {16'h0, STATION[47:32]});
        wr(12'h404, STATION[31:0]);
        wr(12'h400, {16'h8000, STATION[47:32]});
        wr(12'h40c, PEER[31:0]);
        wr(12'h408, {16'hc000, PEER[47:32]});
        for (int v = 1; v >= 0; v--) begin
            fill(STATION);
            frame(1'b1, 1'b0, 1'b0, 2, 1'b1, 32'h0803);
            chk("perfect_da_hit", 32'(v), {31'h0, perfect_da_hit});
            chk("perfect_sa_hit", 32'h1, {31'h0, perfect_sa_hit});
            wr(12'h400, {16'h0, STATION[47:32]});
        end
        wr(12'h144, 32'h1f00);
        // The last pass drops every wake enable, so no source may fire.
        for (int s = 0; s < 3; s++) begin
            @(posedge clock);
            entering_suspend <= (s == 0);
            waking_up <= (s == 1);
            wake_en <= (s == 2) ? 5'h0 : 5'h1f;
            frame(1'b1, 1'b1, 1'b1, 0, 1'b0, 32'h3);
        end
        @(posedge clock);
        {entering_suspend, waking_up, wake_en} <= 7'h1f;
        @(posedge clock);
        {image_cfg, image_mask, image_load} <=
            {32'hffff1234, {4{32'h0f0f0f0f}}, 1'b1};
        @(posedge clock);
        image_load <= 1'b0;
        for (int r = 0; r < 2; r++) begin
            wr(12'h150, 32'h0);
            wr(12'h20c, 32'h0);
            wr(12'h158, 32'h80000001);
            @(posedge clock);
            {usb_reset, lite_reset} <= {r == 0, r == 1};
            @(posedge clock);
            {usb_reset, lite_reset} <= 2'h0;
            rdchk("cfg filter 0", 12'h150, 32'h83ff1234);
            rdchk("mask filter 0", 12'h20c, 32'h0f0f0f0f);
            rdchk("cfg filter 2", 12'h158, 32'h0);
            rdchk("wake_source_status", 12'h144, 32'h3);
        end
        print_verdict();
    end
endmodule // tb_wakeup_frame_filter
`default_nettype wire

// ---- bench/wff_rx_source.sv ----
`timescale 1ns/1ps
`default_nettype none
module wff_rx_source (
    input  wire logic       clock,
    output var  logic       rx_sof,
    output var  logic       rx_valid,
    output var  logic [7:0] rx_data,
    output var  logic       rx_eof,
    output var  logic       rx_frame_ok,
    output var  logic       rx_filter_pass,
    output var  logic       rx_magic_packet
);
    logic [7:0] frame_bytes [64];
    initial begin
        {rx_sof, rx_valid, rx_eof} = 3'h0;
        {rx_frame_ok, rx_filter_pass, rx_magic_packet} = 3'h0;
        rx_data = 8'h0;
    end
    // Idle data is inverted so a stale byte can never pass for a fresh one.
    task automatic send(input int len, input logic ok, pass, magic,
                        input int gap);
        for (int i = 0; i < len; i++) begin
            @(posedge clock);
            rx_sof <= (i == 0);
            rx_valid <= 1'b1;
            rx_data <= frame_bytes[i];
            repeat (gap) begin
                @(posedge clock);
                rx_sof <= 1'b0;
                rx_valid <= 1'b0;
                rx_data <= ~frame_bytes[i];
            end
        end
        @(posedge clock);
        {rx_sof, rx_valid} <= 2'h0;
        rx_data <= ~frame_bytes[len-1];
        rx_eof <= 1'b1;
        {rx_frame_ok, rx_filter_pass, rx_magic_packet} <= {ok, pass, magic};
        @(posedge clock);
        rx_eof <= 1'b0;
        {rx_frame_ok, rx_filter_pass, rx_magic_packet} <= ~{ok, pass, magic};
    endtask
endmodule // wff_rx_source
`default_nettype wire

// ---- bench/wff_wake_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module wff_wake_monitor (
    input wire logic        clock,
    input wire logic        nrst,
    input wire logic        usb_reset,
    input wire logic        lite_reset,
    input wire logic        bus_rd,
    input wire logic [31:0] bus_rdata,
    input wire logic        rx_eof,
    input wire logic        rx_frame_ok,
    input wire logic        rx_filter_pass,
    input wire logic        rx_magic_packet,
    input wire logic        filter_engine_wake_en,
    input wire logic        magic_packet_wake_en,
    input wire logic        entering_suspend,
    input wire logic        waking_up,
    input wire logic        wake_signal,
    input wire logic        perfect_da_hit
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    sequence s_good_eof;
        rx_eof && rx_frame_ok && !entering_suspend && !waking_up;
    endsequence
    sequence s_quiet_eof;
        rx_eof && (!rx_frame_ok || entering_suspend || waking_up);
    endsequence
    AST_ENGINE_WAKE: assert property (
        s_good_eof ##0 (rx_filter_pass && filter_engine_wake_en)
        |=> wake_signal) else $error("engine wake missing");
    AST_MAGIC_WAKE: assert property (
        s_good_eof ##0 (rx_magic_packet && magic_packet_wake_en)
        |=> wake_signal) else $error("magic wake missing");
    AST_QUIET_EOF: assert property (
        s_quiet_eof |=> !wake_signal) else $error("wake from dropped frame");
    AST_WAKE_CAUSE: assert property (
        wake_signal |-> $past(rx_eof && rx_frame_ok))
        else $error("wake without good frame end");
    AST_WAKE_PULSE: assert property (
        wake_signal |=> !wake_signal) else $error("wake longer than a cycle");
    // Soft reset may clear the table, so the hit is only frozen outside it.
    AST_HIT_HOLD: assert property (
        !(rx_eof && rx_frame_ok) && !usb_reset && !lite_reset
        |=> $stable(perfect_da_hit)) else $error("hit moved between frames");
    AST_HIT_RISE: assert property (
        $rose(perfect_da_hit) |-> $past(rx_eof && rx_frame_ok))
        else $error("hit rose without frame end");
    AST_RDATA_IDLE: assert property (
        !$past(bus_rd) |-> bus_rdata == 32'h0)
        else $error("read data outside read slot");
endmodule // wff_wake_monitor
bind wff_wake_filter wff_wake_monitor u_mon (.clock, .nrst, .usb_reset,
    .lite_reset, .bus_rd, .bus_rdata, .rx_eof, .rx_frame_ok, .rx_filter_pass,
    .rx_magic_packet, .filter_engine_wake_en, .magic_packet_wake_en,
    .entering_suspend, .waking_up, .wake_signal, .perfect_da_hit);
`default_nettype wire

// ---- rtl/wff_address_entry.v ----
`timescale 1ns/1ps
`default_nettype none

`include "wff_consts.vh"

module wff_address_entry (
    input  wire [31:0] entry_word0,
    input  wire [31:0] entry_word1,
    input  wire [47:0] dest_addr,
    input  wire [47:0] src_addr,
    output wire        dest_hit,
    output wire        src_hit
);
    wire [47:0] entry_addr = {entry_word0[`WFF_ENT_ADDR_HI:0],
                              entry_word1};
    wire        valid      = entry_word0[`WFF_ENT_VALID];
    wire        is_source  = entry_word0[`WFF_ENT_SOURCE];

    assign dest_hit = valid && !is_source &&
                      (entry_addr == dest_addr);
    assign src_hit  = valid && is_source &&
                      (entry_addr == src_addr);

endmodule // wff_address_entry

`default_nettype wire

// ---- rtl/wff_consts.vh ----
`ifndef WFF_CONSTS_VH
`define WFF_CONSTS_VH

// Register map, byte addresses.
`define WFF_OFS_WAKE_SRC   12'h144
`define WFF_OFS_CFG_BASE   12'h150
`define WFF_OFS_CFG_LAST   12'h1cc
`define WFF_OFS_MASK_BASE  12'h200
`define WFF_OFS_MASK_LAST  12'h3fc
`define WFF_OFS_ADDR_BASE  12'h400
`define WFF_OFS_ADDR_LAST  12'h504

// Wake source status layout.
`define WFF_BIT_FILTER_ENGINE  12
`define WFF_BIT_OWN_ADDRESS    11
`define WFF_BIT_MAGIC_PACKET   10
`define WFF_BIT_BROADCAST      9
`define WFF_BIT_PATTERN_FRAME  8
`define WFF_IDX_HI             4
`define WFF_IDX_LO             0

// Wake filter configuration layout.
`define WFF_CFG_ENABLE     31
`define WFF_CFG_TYPE_MCAST 25
`define WFF_CFG_TYPE_ALL   24
`define WFF_CFG_OFS_HI     23
`define WFF_CFG_OFS_LO     16
`define WFF_CFG_CRC_HI     15
`define WFF_CFG_CRC_LO     0
`define WFF_CFG_WMASK      32'h83ffffff

// Exact address filter entry layout.
`define WFF_ENT_VALID      31
`define WFF_ENT_SOURCE     30
`define WFF_ENT_ADDR_HI    15
`define WFF_ENT_WMASK      32'hc000ffff

// CRC-16 engine.
`define WFF_CRC_POLY       16'h8005
`define WFF_CRC_INIT       16'hffff

// Frame byte positions.
`define WFF_POS_MAX        9'h1ff
`define WFF_DA_END         9'h006
`define WFF_SA_END         9'h00c
`define WFF_SA_START       9'h006

`endif

// ---- rtl/wff_pattern_lane.v ----
`timescale 1ns/1ps
`default_nettype none

`include "wff_consts.vh"

module wff_pattern_lane #(
    parameter MASK_BITS = 128
) (
    input  wire                 clock,
    input  wire                 nrst,
    input  wire                 frame_start,
    input  wire                 byte_valid,
    input  wire [7:0]           byte_data,
    input  wire [8:0]           byte_pos,
    input  wire [7:0]           pattern_offset,
    input  wire [MASK_BITS-1:0] byte_mask,
    input  wire [15:0]          crc_expected,
    output wire                 crc_match
);
    localparam IW = $clog2(MASK_BITS);

    reg  [15:0] crc_reg;
    reg  [15:0] crc_base;
    wire [8:0]  ofs_ext   = {1'b0, pattern_offset};
    wire [8:0]  rel       = byte_pos - ofs_ext;
    wire        in_window = (byte_pos >= ofs_ext) && (rel < MASK_BITS);
    wire        take      = byte_valid && in_window &&
                            byte_mask[rel[IW-1:0]];

    // Bits enter least significant first, as they leave the wire.
    function [15:0] crc_step;
        input [15:0] crc_in;
        input [7:0]  data;
        integer b;
        reg [15:0] c;
        begin
            c = crc_in;
            for (b = 0; b < 8; b = b + 1) begin
                if (c[15] ^ data[b]) begin
                    c = {c[14:0], 1'b0} ^ `WFF_CRC_POLY;
                end else begin
                    c = {c[14:0], 1'b0};
                end
            end
            crc_step = c;
        end
    endfunction

    always @* begin
        crc_base = frame_start ? `WFF_CRC_INIT : crc_reg;
    end

    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            crc_reg <= `WFF_CRC_INIT;
        end else if (take) begin
            crc_reg <= crc_step(crc_base, byte_data);
        end else if (frame_start) begin
            crc_reg <= `WFF_CRC_INIT;
        end
    end

    assign crc_match = (crc_reg == crc_expected);

endmodule // wff_pattern_lane

`default_nettype wire

// ---- rtl/wff_wake_filter.v ----
// Function
// - Set bit 12 when an error-free frame passing filter engine causes wake.
// - Set bit 11 when a valid frame to our station address causes wake.
// - Set bit 10 when a valid magic packet causes wake.
// - Set bit 9 when a valid broadcast frame causes wake.
// - Set bit 8 when a valid pattern wake frame causes wake.
// - Bits 4:0 hold matching filter index, valid while bit 8 set.
// - Thirty-two pattern filters, each covering up to 128 frame bytes.
// - A filter is used only while its config bit 31 is one.
// - Bits 25:24 select unicast 00, multicast 10, or all frames X1.
// - CRC starts at frame byte given by offset bits 23:16.
// - CRC-16 equal to bits 15:0 marks a wake frame.
// - Mask bit j feeds byte offset+j into the CRC, else skipped.
// - Each 128-bit mask is four words, lowest address holds bits 31:0.
// - Filter zero restores its loaded image on USB or lite reset.
// - Filter zero config and mask are reloaded, not cleared, on soft reset; nrst clears them.
// - An exact address entry is used only while its valid bit is set.
// - Entry bit 30 selects source address match, else destination match.
// - Address bits 47:32 in low half of word 0, 31:0 in word 1.
// - Wake source bits stay set until software clears them.
// - A frame meeting several wake conditions sets every matching bit.
// - No wake recording while entering suspend or after wake-up begins.
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none

`include "wff_consts.vh"

module wff_wake_filter #(
    parameter NUM_FILTERS = 32,
    parameter MASK_BITS   = 128,
    parameter NUM_ENTRIES = 33
) (
    input  wire                   clock,
    input  wire                   nrst,
    input  wire                   usb_reset,
    input  wire                   lite_reset,
    input  wire                   image_load,
    input  wire [31:0]            image_cfg,
    input  wire [MASK_BITS-1:0]   image_mask,
    input  wire [11:0]            bus_addr,
    input  wire [31:0]            bus_wdata,
    input  wire                   bus_wr,
    input  wire                   bus_rd,
    output reg  [31:0]            bus_rdata,
    input  wire                   rx_sof,
    input  wire                   rx_valid,
    input  wire [7:0]             rx_data,
    input  wire                   rx_eof,
    input  wire                   rx_frame_ok,
    input  wire                   rx_filter_pass,
    input  wire                   rx_magic_packet,
    input  wire [47:0]            station_address,
    input  wire                   filter_engine_wake_en,
    input  wire                   own_address_wake_en,
    input  wire                   magic_packet_wake_en,
    input  wire                   broadcast_wake_en,
    input  wire                   pattern_frame_wake_en,
    input  wire                   entering_suspend,
    input  wire                   waking_up,
    output reg                    wake_signal,
    output reg                    perfect_da_hit,
    output reg                    perfect_sa_hit
);
    localparam MASK_WORDS = MASK_BITS / 32;

    reg  [31:0] cfg_mem  [0:NUM_FILTERS-1];
    reg  [31:0] mask_mem [0:NUM_FILTERS*MASK_WORDS-1];
    reg  [31:0] ent_mem  [0:NUM_ENTRIES*2-1];
    reg  [31:0]          img_cfg_reg;
    reg  [MASK_BITS-1:0] img_mask_reg;
    reg  [8:0]  pos_reg;
    reg  [47:0] da_reg;
    reg  [47:0] sa_reg;
    reg  [4:0]  flags_reg;
    reg  [4:0]  flags_next;
    reg  [4:0]  index_reg;
    reg  [4:0]  hit_index;
    integer     i;
    integer     k;

    wire soft_reset = usb_reset | lite_reset;

    // Address decode; unaligned or unmapped addresses read as zero.
    wire        aligned   = (bus_addr[1:0] == 2'b00);
    wire        sel_src   = (bus_addr == `WFF_OFS_WAKE_SRC);
    wire        sel_cfg   = aligned && (bus_addr >= `WFF_OFS_CFG_BASE) &&
                            (bus_addr <= `WFF_OFS_CFG_LAST);
    wire        sel_mask  = aligned && (bus_addr >= `WFF_OFS_MASK_BASE) &&
                            (bus_addr <= `WFF_OFS_MASK_LAST);
    wire        sel_ent   = aligned && (bus_addr >= `WFF_OFS_ADDR_BASE) &&
                            (bus_addr <= `WFF_OFS_ADDR_LAST);
    wire [11:0] cfg_rel   = bus_addr - `WFF_OFS_CFG_BASE;
    wire [11:0] mask_rel  = bus_addr - `WFF_OFS_MASK_BASE;
    wire [11:0] ent_rel   = bus_addr - `WFF_OFS_ADDR_BASE;
    wire [4:0]  cfg_idx   = cfg_rel[6:2];
    wire [6:0]  mask_idx  = mask_rel[8:2];
    wire [6:0]  ent_idx   = ent_rel[8:2];

    // Register file. Soft reset wipes the table but brings filter zero back
    // to its loaded image, so a wake pattern set by the loader survives.
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            for (i = 0; i < NUM_FILTERS; i = i + 1) begin
                cfg_mem[i] <= 32'h0;
            end
            for (i = 0; i < NUM_FILTERS * MASK_WORDS; i = i + 1) begin
                mask_mem[i] <= 32'h0;
            end
            for (i = 0; i < NUM_ENTRIES * 2; i = i + 1) begin
                ent_mem[i] <= 32'h0;
            end
            img_cfg_reg  <= 32'h0;
            img_mask_reg <= {MASK_BITS{1'b0}};
        end else if (soft_reset) begin
            for (i = 1; i < NUM_FILTERS; i = i + 1) begin
                cfg_mem[i] <= 32'h0;
            end
            for (i = MASK_WORDS; i < NUM_FILTERS * MASK_WORDS; i = i + 1) begin
                mask_mem[i] <= 32'h0;
            end
            for (i = 0; i < NUM_ENTRIES * 2; i = i + 1) begin
                ent_mem[i] <= 32'h0;
            end
            cfg_mem[0] <= img_cfg_reg & `WFF_CFG_WMASK;
            for (i = 0; i < MASK_WORDS; i = i + 1) begin
                mask_mem[i] <= img_mask_reg[i*32 +: 32];
            end
        end else if (image_load) begin
            img_cfg_reg  <= image_cfg;
            img_mask_reg <= image_mask;
            cfg_mem[0]   <= image_cfg & `WFF_CFG_WMASK;
            for (i = 0; i < MASK_WORDS; i = i + 1) begin
                mask_mem[i] <= image_mask[i*32 +: 32];
            end
        end else if (bus_wr) begin
            if (sel_cfg) begin
                cfg_mem[cfg_idx] <= bus_wdata & `WFF_CFG_WMASK;
            end
            if (sel_mask) begin
                mask_mem[mask_idx] <= bus_wdata;
            end
            if (sel_ent) begin
                if (ent_idx[0]) begin
                    ent_mem[ent_idx] <= bus_wdata;
                end else begin
                    ent_mem[ent_idx] <= bus_wdata & `WFF_ENT_WMASK;
                end
            end
        end
    end

    // Read data stands in the cycle after the strobe only.
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            bus_rdata <= 32'h0;
        end else if (bus_rd) begin
            if (sel_src) begin
                bus_rdata <= {19'h0, flags_reg, 3'h0, index_reg};
            end else if (sel_cfg) begin
                bus_rdata <= cfg_mem[cfg_idx];
            end else if (sel_mask) begin
                bus_rdata <= mask_mem[mask_idx];
            end else if (sel_ent) begin
                bus_rdata <= ent_mem[ent_idx];
            end else begin
                bus_rdata <= 32'h0;
            end
        end else begin
            bus_rdata <= 32'h0;
        end
    end

    // Frame byte position and address capture.
    wire [8:0] pos_cur = rx_sof ? 9'h0 : pos_reg;
    wire [8:0] sa_pos  = pos_cur - `WFF_SA_START;

    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pos_reg <= 9'h0;
            da_reg  <= 48'h0;
            sa_reg  <= 48'h0;
        end else if (rx_valid) begin
            if (pos_cur != `WFF_POS_MAX) begin
                pos_reg <= pos_cur + 9'h1;
            end else begin
                pos_reg <= pos_cur;
            end
            if (pos_cur < `WFF_DA_END) begin
                da_reg[pos_cur[2:0]*8 +: 8] <= rx_data;
            end else if (pos_cur < `WFF_SA_END) begin
                sa_reg[sa_pos[2:0]*8 +: 8] <= rx_data;
            end
        end else if (rx_sof) begin
            pos_reg <= 9'h0;
        end
    end

    // First address byte carries the group bit in its lowest bit.
    wire is_multicast = da_reg[0];
    wire is_broadcast = (da_reg == {48{1'b1}});

    // Pattern filter lanes.
    wire [NUM_FILTERS-1:0] lane_crc_ok;
    wire [NUM_FILTERS-1:0] lane_hit;
    genvar g;
    generate
        for (g = 0; g < NUM_FILTERS; g = g + 1) begin : g_lane
            wire [31:0] cfg = cfg_mem[g];
            wire        type_ok = cfg[`WFF_CFG_TYPE_ALL] ||
                (cfg[`WFF_CFG_TYPE_MCAST] == is_multicast);
            wff_pattern_lane #(
                .MASK_BITS (MASK_BITS)
            ) u_lane (
                .clock          (clock),
                .nrst           (nrst),
                .frame_start    (rx_sof),
                .byte_valid     (rx_valid),
                .byte_data      (rx_data),
                .byte_pos       (pos_cur),
                .pattern_offset (cfg[`WFF_CFG_OFS_HI:`WFF_CFG_OFS_LO]),
                .byte_mask      ({mask_mem[g*4+3], mask_mem[g*4+2],
                                  mask_mem[g*4+1], mask_mem[g*4]}),
                .crc_expected   (cfg[`WFF_CFG_CRC_HI:`WFF_CFG_CRC_LO]),
                .crc_match      (lane_crc_ok[g])
            );
            assign lane_hit[g] = cfg[`WFF_CFG_ENABLE] && type_ok &&
                                 lane_crc_ok[g];
        end
    endgenerate

    // Exact address table.
    wire [NUM_ENTRIES-1:0] ent_da_hit;
    wire [NUM_ENTRIES-1:0] ent_sa_hit;
    generate
        for (g = 0; g < NUM_ENTRIES; g = g + 1) begin : g_entry
            wff_address_entry u_entry (
                .entry_word0 (ent_mem[g*2]),
                .entry_word1 (ent_mem[g*2+1]),
                .dest_addr   (da_reg),
                .src_addr    (sa_reg),
                .dest_hit    (ent_da_hit[g]),
                .src_hit     (ent_sa_hit[g])
            );
        end
    endgenerate

    // Lowest numbered matching filter is reported.
    always @* begin
        hit_index = 5'h0;
        for (k = NUM_FILTERS - 1; k >= 0; k = k - 1) begin
            if (lane_hit[k]) begin
                hit_index = k[4:0];
            end
        end
    end

    // Wake decision at the end of an error-free frame.
    wire good_end  = rx_eof && rx_frame_ok;
    wire armed     = !entering_suspend && !waking_up;
    wire w_engine  = filter_engine_wake_en && rx_filter_pass;
    wire w_own     = own_address_wake_en && (da_reg == station_address);
    wire w_magic   = magic_packet_wake_en && rx_magic_packet;
    wire w_bcast   = broadcast_wake_en && is_broadcast;
    wire w_pattern = pattern_frame_wake_en && (|lane_hit);
    wire [4:0] wake_set = (good_end && armed) ?
                          {w_engine, w_own, w_magic, w_bcast, w_pattern} :
                          5'h0;
    wire src_wr = bus_wr && sel_src;

    // A set in the same cycle as a write-one-to-clear wins.
    always @* begin
        flags_next = flags_reg;
        if (src_wr) begin
            flags_next = flags_reg &
                ~bus_wdata[`WFF_BIT_FILTER_ENGINE:`WFF_BIT_PATTERN_FRAME];
        end
        flags_next = flags_next | wake_set;
    end

    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            flags_reg      <= 5'h0;
            index_reg      <= 5'h0;
            wake_signal    <= 1'b0;
            perfect_da_hit <= 1'b0;
            perfect_sa_hit <= 1'b0;
        end else begin
            flags_reg   <= flags_next;
            wake_signal <= |wake_set;
            if (wake_set[0]) begin
                index_reg <= hit_index;
            end
            if (good_end) begin
                perfect_da_hit <= |ent_da_hit;
                perfect_sa_hit <= |ent_sa_hit;
            end
        end
    end

endmodule // wff_wake_filter

`default_nettype wire
